// ==== design/drt_pkg.sv ====
// Operation
// - Select bit routes DMA cycles to DMA fields
// - DMA fields in bits 5:0, gated by select
// - Ras-cas delay clear adds no strobe wait
// - Stretch bit sets full or half cas low
// - Wait count code inserts zero to three waits
// - Bank width: byte, half, word, reserved
// - Test control register is write-only
// - Column test bit: nibbles count independently
// - Force bit steps refresh counter every cycle while refresh is enabled
// - Size force resets to 10, forces byte/half
// - Ten-bit column incrementer during bursts
// - Seven-bit refresh down counter, reload at zero
package drt_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the register select address
    // ----------------------------------------------------------------
    localparam logic [3:0] DRT_OFF_REFRESH = 4'h0;
    localparam logic [3:0] DRT_OFF_CPU = 4'h4;
    localparam logic [3:0] DRT_OFF_DMA = 4'h8;
    localparam logic [3:0] DRT_OFF_TEST = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DRT_SEL_BIT = 6;
    localparam int DRT_TIMING_MSB = 5;
    localparam int DRT_TEST_MSB = 3;
    localparam int DRT_RFSH_EN_BIT = 7;
    localparam int DRT_RFDIV_MSB = 6;
    localparam int DRT_REFCNT_LSB = 8;
    localparam int DRT_REFCNT_MSB = 15;

    // ----------------------------------------------------------------
    // Access size and bank width codes
    // ----------------------------------------------------------------
    localparam logic [1:0] DRT_SIZE_BYTE = 2'h0;
    localparam logic [1:0] DRT_SIZE_HALF = 2'h1;
    localparam logic [1:0] DRT_SIZE_BUS = 2'h2;
    localparam logic [1:0] DRT_WIDTH_RSVD = 2'h3;

    // ----------------------------------------------------------------
    // Column incrementer shape
    // ----------------------------------------------------------------
    localparam int DRT_COL_W = 10;
    localparam int DRT_NIB_W = 4;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ras_cas_delay;
        logic cas_low_stretch;
        logic [1:0] wait_count;
        logic [1:0] bank_width;
    } drt_timing_t;

    typedef struct packed {
        logic column_inc_test;
        logic refresh_step_force;
        logic [1:0] access_size_force;
    } drt_test_t;

    typedef struct packed {
        logic [15:0] refresh_ctl;
        logic dma_timing_select;
        drt_timing_t cpu;
        drt_timing_t dma;
        drt_test_t test;
        logic [7:0] div_cnt;
        logic [6:0] ref_cnt;
        logic ref_req;
        logic [31:0] rd_data;
        logic rd_oe;
    } drt_state_t;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DRT_RST_REFRESH = 16'h0000;
    localparam drt_timing_t DRT_RST_TIMING = 6'h00;
    localparam drt_test_t DRT_RST_TEST = 4'h2;
    localparam logic [7:0] DRT_RST_DIV = 8'h00;
    localparam logic [6:0] DRT_RST_REF = 7'h00;

endpackage

// ==== design/drt_col_nibble.sv ====
`timescale 1ns/1ns
// One slice of the column address incrementer
module drt_col_nibble #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic step,
    output logic [W-1:0] value,
    output logic carry
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [W-1:0] cnt_ff; // Slice count
    logic [W-1:0] nxt_cnt; // Next slice count

    // Load wins over step so a burst start is never skewed
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = load_val;
        end else if (step) begin
            nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Register the slice
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign value = cnt_ff;
    // Ripple carry to the next slice, only when this slice steps
    assign carry = step & (&cnt_ff);
endmodule // drt_col_nibble

// ==== design/drt_timing_regs.sv ====
`timescale 1ns/1ns
module drt_timing_regs
    import drt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Register access
    input wire logic reg_sel,
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic [31:0] bd_in,
    output logic [31:0] bd_out,
    output logic bd_oe,
    // Cycle context from the strobe machine
    input wire logic dma_master,
    input wire logic [1:0] bus_size,
    input wire logic col_load,
    input wire logic [9:0] col_load_addr,
    input wire logic col_inc,
    // Timing for the strobe machine
    output drt_timing_t timing,
    output logic rc_extra_cycle,
    output logic cas_low_full,
    output logic [1:0] wait_states,
    output logic bank_width_bad,
    output logic [1:0] access_size,
    output logic [9:0] col_addr,
    output logic refresh_req,
    output logic refresh_step
);
    // ----------------------------------------------------------------
    // State and decode
    // ----------------------------------------------------------------
    drt_state_t st_ff; // All registered state
    drt_state_t nxt_st; // Next state
    logic wr_hit; // Register write this cycle
    logic rd_hit; // Register read this cycle
    logic ref_tick; // Divided refresh clock pulse
    logic [7:0] refcnt; // Refresh clock divisor
    logic [6:0] rfdiv; // Refresh reload value
    logic rfsh_en; // Refresh enable
    logic [2:0] nib_step; // Step per column slice
    logic [2:0] nib_carry; // Carry out per slice

    assign wr_hit = reg_sel & reg_write;
    assign rd_hit = reg_sel & ~reg_write;
    assign refcnt = st_ff.refresh_ctl[DRT_REFCNT_MSB:DRT_REFCNT_LSB];
    assign rfdiv = st_ff.refresh_ctl[DRT_RFDIV_MSB:0];
    assign rfsh_en = st_ff.refresh_ctl[DRT_RFSH_EN_BIT];

    // ----------------------------------------------------------------
    // Timing set selection
    // ----------------------------------------------------------------
    // DMA set only for DMA cycles with the select bit set
    always_comb begin
        if (dma_master && st_ff.dma_timing_select) begin
            timing = st_ff.dma;
        end else begin
            timing = st_ff.cpu;
        end
    end

    // Derived strobe controls for the state machine
    assign rc_extra_cycle = timing.ras_cas_delay;
    assign cas_low_full = timing.cas_low_stretch;
    assign wait_states = timing.wait_count;
    // Reserved width flagged so the state machine can refuse it
    assign bank_width_bad = (timing.bank_width == DRT_WIDTH_RSVD);

    // Forced size; code 11 falls back to the bus size
    always_comb begin
        unique case (st_ff.test.access_size_force)
            DRT_SIZE_BYTE: access_size = DRT_SIZE_BYTE;
            DRT_SIZE_HALF: access_size = DRT_SIZE_HALF;
            default: access_size = bus_size;
        endcase
    end

    // ----------------------------------------------------------------
    // Refresh divider tick
    // ----------------------------------------------------------------
    // A zero divisor never ticks, matching the no-refresh hazard
    assign ref_tick = (refcnt != 8'h00) && (st_ff.div_cnt == refcnt - 8'h01);
    // Force bit bypasses the divider entirely
    assign refresh_step = rfsh_en &
        (st_ff.test.refresh_step_force | ref_tick);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ref_req = 1'b0;
        nxt_st.rd_oe = rd_hit;
        nxt_st.rd_data = 32'h0000_0000;
        // Register writes; upper bits dropped
        if (wr_hit) begin
            unique case (reg_addr)
                DRT_OFF_REFRESH: begin
                    nxt_st.refresh_ctl = bd_in[15:0];
                end
                DRT_OFF_CPU: begin
                    nxt_st.dma_timing_select = bd_in[DRT_SEL_BIT];
                    nxt_st.cpu = bd_in[DRT_TIMING_MSB:0];
                end
                DRT_OFF_DMA: begin
                    nxt_st.dma = bd_in[DRT_TIMING_MSB:0];
                end
                DRT_OFF_TEST: begin
                    nxt_st.test = bd_in[DRT_TEST_MSB:0];
                end
                default: begin
                end
            endcase
        end
        // Readable registers only; test and refresh read zero
        if (rd_hit) begin
            unique case (reg_addr)
                DRT_OFF_CPU: begin
                    nxt_st.rd_data = {25'h0,
                        st_ff.dma_timing_select, st_ff.cpu};
                end
                DRT_OFF_DMA: begin
                    nxt_st.rd_data = {26'h0, st_ff.dma};
                end
                default: begin
                    nxt_st.rd_data = 32'h0000_0000;
                end
            endcase
        end
        // Divider runs only while refresh is enabled; a new setting
        // restarts it, so a smaller divisor never waits for a wrap
        if (!rfsh_en || ref_tick ||
                (wr_hit && reg_addr == DRT_OFF_REFRESH)) begin
            nxt_st.div_cnt = DRT_RST_DIV;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
        end
        // Down counter, request at zero then reload
        if (refresh_step) begin
            if (st_ff.ref_cnt == 7'h00) begin
                nxt_st.ref_cnt = rfdiv;
                nxt_st.ref_req = 1'b1;
            end else begin
                nxt_st.ref_cnt = st_ff.ref_cnt - 7'h01;
            end
        end
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff.refresh_ctl <= DRT_RST_REFRESH;
            st_ff.dma_timing_select <= 1'b0;
            st_ff.cpu <= DRT_RST_TIMING;
            st_ff.dma <= DRT_RST_TIMING;
            st_ff.test <= DRT_RST_TEST;
            st_ff.div_cnt <= DRT_RST_DIV;
            st_ff.ref_cnt <= DRT_RST_REF;
            st_ff.ref_req <= 1'b0;
            st_ff.rd_data <= 32'h0000_0000;
            st_ff.rd_oe <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read port and refresh pulse come straight from flops
    assign bd_out = st_ff.rd_data;
    assign bd_oe = st_ff.rd_oe;
    assign refresh_req = st_ff.ref_req;

    // ----------------------------------------------------------------
    // Column address incrementer
    // ----------------------------------------------------------------
    // Test mode feeds every slice the raw step; else carries ripple
    assign nib_step[0] = col_inc;
    assign nib_step[1] = st_ff.test.column_inc_test ? col_inc
                                                   : nib_carry[0];
    assign nib_step[2] = st_ff.test.column_inc_test ? col_inc
                                                   : nib_carry[1];

    // Low slice always sees the raw step
    drt_col_nibble #(.W(DRT_NIB_W)) u_nib0 (
        .clk(clk),
        .rst(rst),
        .load(col_load),
        .load_val(col_load_addr[3:0]),
        .step(nib_step[0]),
        .value(col_addr[3:0]),
        .carry(nib_carry[0])
    );

    // Middle slice
    drt_col_nibble #(.W(DRT_NIB_W)) u_nib1 (
        .clk(clk),
        .rst(rst),
        .load(col_load),
        .load_val(col_load_addr[7:4]),
        .step(nib_step[1]),
        .value(col_addr[7:4]),
        .carry(nib_carry[1])
    );

    // Top slice is the short two-bit remainder of the ten bits
    drt_col_nibble #(.W(DRT_COL_W - 2 * DRT_NIB_W)) u_nib2 (
        .clk(clk),
        .rst(rst),
        .load(col_load),
        .load_val(col_load_addr[9:8]),
        .step(nib_step[2]),
        .value(col_addr[9:8]),
        .carry(nib_carry[2])
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_dma_set_used: assert property (
        dma_master && st_ff.dma_timing_select |-> timing == st_ff.dma)
        else $error("DMA timing set not used");
    a_cpu_set_default: assert property (
        !st_ff.dma_timing_select |-> timing == st_ff.cpu)
        else $error("CPU timing set not used");
    a_cpu_for_cpu: assert property (
        !dma_master |-> timing == st_ff.cpu)
        else $error("CPU cycle used DMA timing");
    a_rc_no_wait: assert property (
        wr_hit && reg_addr == DRT_OFF_CPU && !bd_in[5] && !dma_master
        |=> !rc_extra_cycle)
        else $error("Ras-cas wait added while clear");
    a_rc_extra_one: assert property (
        wr_hit && reg_addr == DRT_OFF_CPU && bd_in[5] && !dma_master
        |=> rc_extra_cycle)
        else $error("Ras-cas extra cycle missing");
    a_wait_follows: assert property (
        wr_hit && reg_addr == DRT_OFF_CPU && !dma_master
        |=> wait_states == $past(bd_in[3:2]) && cas_low_full == $past(bd_in[4]))
        else $error("Wait or cas stretch not taken");
    a_test_reads_zero: assert property (
        rd_hit && reg_addr == DRT_OFF_TEST |=> bd_oe && bd_out == 32'h0)
        else $error("Test register readable");
    a_rsvd_read_zero: assert property (
        rd_hit && reg_addr == DRT_OFF_CPU |=> bd_out[31:7] == 25'h0)
        else $error("Reserved bits read nonzero");
    a_nibble_indep: assert property (
        st_ff.test.column_inc_test && col_inc && !col_load
        |=> col_addr[7:4] == $past(col_addr[7:4]) + 4'h1)
        else $error("Test nibble did not step");
    a_col_carry: assert property (
        !st_ff.test.column_inc_test && col_inc && !col_load
        |=> col_addr == $past(col_addr) + 10'h001)
        else $error("Column incrementer wrong");
    a_force_step: assert property (
        rfsh_en && st_ff.test.refresh_step_force && st_ff.ref_cnt != 7'h0
        && !wr_hit |=> st_ff.ref_cnt == $past(st_ff.ref_cnt) - 7'h01)
        else $error("Forced refresh step missing");
    a_refresh_reload: assert property (
        refresh_step && st_ff.ref_cnt == 7'h0
        |=> refresh_req && st_ff.ref_cnt == $past(rfdiv) ##1 !refresh_req)
        else $error("Refresh reload or request wrong");
    a_size_forced: assert property (
        st_ff.test.access_size_force == DRT_SIZE_BYTE
        |-> access_size == DRT_SIZE_BYTE)
        else $error("Byte size not forced");
    a_width_rsvd: assert property (
        bank_width_bad == (&timing[1:0]))
        else $error("Reserved width flag wrong");

    // Register port checks
    a_dma_write: assert property (
        wr_hit && reg_addr == DRT_OFF_DMA |=> st_ff.dma == $past(bd_in[5:0]))
        else $error("DMA timing write not taken");
    a_idle_read_zero: assert property (
        !rd_hit |=> !bd_oe && bd_out == 32'h0)
        else $error("Read port not idle");

    // Size and refresh checks
    a_size_half: assert property (
        st_ff.test.access_size_force == DRT_SIZE_HALF
        |-> access_size == DRT_SIZE_HALF)
        else $error("Half size not forced");
    a_size_bus: assert property (
        st_ff.test.access_size_force == DRT_SIZE_BUS
        |-> access_size == bus_size)
        else $error("Bus size not passed");
    a_step_gated: assert property (
        !rfsh_en |-> !refresh_step)
        else $error("Refresh stepped while disabled");
    a_force_every: assert property (
        rfsh_en && st_ff.test.refresh_step_force |-> refresh_step)
        else $error("Forced step not every cycle");

    // Scenario covers
    c_dma_cycle: cover property (dma_master && st_ff.dma_timing_select);
    c_refresh_req: cover property (refresh_req);
    c_test_inc: cover property (st_ff.test.column_inc_test && col_inc);
    c_reg_read: cover property (rd_hit ##1 bd_oe);
    c_test_write: cover property (wr_hit && reg_addr == DRT_OFF_TEST);
endmodule // drt_timing_regs

// ==== tb/drt_bus_master.sv ====
`timescale 1ns/1ns
// ---------------------------------------------
// Bus master model: CPU core or DMA engine
// ---------------------------------------------
module drt_bus_master (
    input wire logic clk,
    output logic reg_sel,
    output logic [3:0] reg_addr,
    output logic reg_write,
    output logic [31:0] bd_in,
    output logic dma_master,
    input wire logic [31:0] bd_out,
    input wire logic bd_oe
);
    // Idle bus, CPU owns it
    initial begin
        reg_sel = 1'b0;
        reg_addr = 4'h0;
        reg_write = 1'b0;
        bd_in = 32'h0;
        dma_master = 1'b0;
    end
    // Hand the bus to CPU or DMA just after an edge
    task automatic set_master(input logic m);
        @(posedge clk) #1;
        dma_master = m;
    endtask
    // One write cycle; released data is scrambled, not held
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        reg_sel = 1'b1;
        reg_write = 1'b1;
        reg_addr = a;
        bd_in = d;
        @(posedge clk) #1;
        reg_sel = 1'b0;
        reg_write = 1'b0;
        reg_addr = ~a;
        bd_in = ~d;
    endtask
    // One read; answer taken in the cycle after the request
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
            output logic oe);
        @(posedge clk) #1;
        reg_sel = 1'b1;
        reg_write = 1'b0;
        reg_addr = a;
        @(posedge clk) #1;
        reg_sel = 1'b0;
        reg_addr = ~a;
        d = bd_out;
        oe = bd_oe;
    endtask
endmodule // drt_bus_master

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import drt_pkg::*;
    logic clk, rst, reg_sel, reg_write, dma_master, col_load, col_inc;
    logic [3:0] reg_addr;
    logic [31:0] bd_in, bd_out, rv, cv, dv;
    logic bd_oe, oe, rc_extra_cycle, cas_low_full, bank_width_bad;
    logic refresh_req, refresh_step;
    logic [1:0] bus_size, wait_states, access_size;
    logic [9:0] col_load_addr, col_addr, ca;
    logic [5:0] ev;
    drt_timing_t timing;
    int seed = 82191;
    int miscompares = 0;
    int check_count = 0;
    // ---------------------------------------------
    // Design, bus master and clock
    // ---------------------------------------------
    drt_timing_regs drt_timing_regs_inst (.clk(clk), .rst(rst),
        .reg_sel(reg_sel), .reg_addr(reg_addr), .reg_write(reg_write),
        .bd_in(bd_in), .bd_out(bd_out), .bd_oe(bd_oe),
        .dma_master(dma_master), .bus_size(bus_size),
        .col_load(col_load), .col_load_addr(col_load_addr),
        .col_inc(col_inc), .timing(timing),
        .rc_extra_cycle(rc_extra_cycle), .cas_low_full(cas_low_full),
        .wait_states(wait_states), .bank_width_bad(bank_width_bad),
        .access_size(access_size), .col_addr(col_addr),
        .refresh_req(refresh_req), .refresh_step(refresh_step));
    drt_bus_master drt_bus_master_inst (.clk(clk), .reg_sel(reg_sel),
        .reg_addr(reg_addr), .reg_write(reg_write), .bd_in(bd_in),
        .dma_master(dma_master), .bd_out(bd_out), .bd_oe(bd_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ---------------------------------------------
    // Expectations and reporting
    // ---------------------------------------------
    // Size codes 10 and 11 pass the bus size through
    function automatic logic [1:0] exp_size(input logic [1:0] f, b);
        return f[1] ? b : f;
    endfunction
    // Test mode splits the counter into 4, 4 and 2 bit slices
    function automatic logic [9:0] exp_col(input logic [9:0] c,
            input logic t);
        if (!t) return c + 10'h1;
        return {c[9:8] + 2'h1, c[7:4] + 4'h1, c[3:0] + 4'h1};
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cycles between two refresh requests, bounded
    task automatic gap(output int n);
        int k;
        for (k = 0; k < 400 && refresh_req !== 1'b1; k++) @(posedge clk) #1;
        @(posedge clk) #1;
        for (n = 1; n < 400 && refresh_req !== 1'b1; n++) @(posedge clk) #1;
        if (n == 400 || k == 400) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // Hang guard
    initial begin
        #900000;
        miscompares++;
        give_verdict();
    end
    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        int i, m, n;
        rst = 1'b1;
        bus_size = 2'h2;
        col_load = 1'b0;
        col_inc = 1'b0;
        col_load_addr = 10'h0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        // Reset state: timing clear, size follows bus, test unreadable
        drt_bus_master_inst.rd(DRT_OFF_CPU, rv, oe);
        chk(rv, 32'h0, "cpu reset");
        chk({31'h0, oe}, 32'h1, "read strobe");
        drt_bus_master_inst.rd(DRT_OFF_TEST, rv, oe);
        chk(rv, 32'h0, "test read");
        chk({30'h0, access_size}, {30'h0, bus_size}, "size rst");
        $display("reset test done");
        // Random timing sets, both masters
        for (i = 0; i < 24; i++) begin
            cv = $random(seed);
            dv = $random(seed);
            drt_bus_master_inst.wr(DRT_OFF_CPU, cv);
            drt_bus_master_inst.wr(DRT_OFF_DMA, dv);
            drt_bus_master_inst.rd(DRT_OFF_CPU, rv, oe);
            chk(rv, {25'h0, cv[6:0]}, "cpu readback");
            drt_bus_master_inst.rd(DRT_OFF_DMA, rv, oe);
            chk(rv, {26'h0, dv[5:0]}, "dma readback");
            // DMA first, so the next writes are made with the CPU
            for (m = 1; m >= 0; m--) begin
                drt_bus_master_inst.set_master(m[0]);
                #2;
                ev = (m[0] && cv[6]) ? dv[5:0] : cv[5:0];
                chk({26'h0, timing}, {26'h0, ev}, "timing");
                chk({28'h0, rc_extra_cycle, cas_low_full, wait_states},
                    {28'h0, ev[5:2]}, "strb");
                chk({31'h0, bank_width_bad}, {31'h0, ev[1:0] == 2'h3},
                    "width");
            end
        end
        // Unlisted offset must not disturb the cpu set
        drt_bus_master_inst.wr(4'h5, 32'hFFFFFFFF);
        drt_bus_master_inst.rd(DRT_OFF_CPU, rv, oe);
        chk(rv, {25'h0, cv[6:0]}, "unlisted write");
        $display("timing test done");
        // Every size force code against bus sizes 0, 1 and 2
        for (i = 0; i < 16; i++) begin
            drt_bus_master_inst.wr(DRT_OFF_TEST, {30'h0, i[3:2]});
            bus_size = i[1:0] % 2'h3;
            #1;
            chk({30'h0, access_size}, {30'h0, exp_size(i[3:2], bus_size)},
                "size force");
        end
        $display("size test done");
        // Column counter: corners then random, normal and test mode
        for (i = 0; i < 16; i++) begin
            ca = (i < 2) ? 10'h12F : (i < 4) ? 10'h3FF : 10'($random(seed));
            drt_bus_master_inst.wr(DRT_OFF_TEST, {28'h0, i[0], 3'h2});
            @(posedge clk) #1;
            col_load = 1'b1;
            col_load_addr = ca;
            @(posedge clk) #1;
            col_load = 1'b0;
            col_inc = 1'b1;
            chk({22'h0, col_addr}, {22'h0, ca}, "col load");
            @(posedge clk) #1;
            col_inc = 1'b0;
            chk({22'h0, col_addr}, {22'h0, exp_col(ca, i[0])},
                "col step");
        end
        $display("column test done");
        // Refresh: forced stepping, then divided stepping
        drt_bus_master_inst.wr(DRT_OFF_TEST, 32'h6);
        drt_bus_master_inst.wr(DRT_OFF_REFRESH, 32'h83);
        gap(n);
        chk(n, 4, "forced period");
        chk({31'h0, refresh_step}, 32'h1, "forced step");
        drt_bus_master_inst.wr(DRT_OFF_TEST, 32'h2);
        drt_bus_master_inst.wr(DRT_OFF_REFRESH, 32'h382);
        gap(n);
        gap(n);
        chk(n, 9, "divided period");
        $display("refresh test done");
        // Mid-run reset: test bits return to their defaults
        drt_bus_master_inst.wr(DRT_OFF_TEST, 32'hC);
        @(posedge clk) #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        bus_size = 2'h1;
        drt_bus_master_inst.wr(DRT_OFF_REFRESH, 32'h83);
        chk({30'h0, access_size}, 32'h1, "size rst");
        chk({31'h0, refresh_step}, 32'h0, "force rst");
        col_load = 1'b1;
        col_load_addr = 10'h0FF;
        @(posedge clk) #1;
        col_load = 1'b0;
        col_inc = 1'b1;
        @(posedge clk) #1;
        col_inc = 1'b0;
        chk({22'h0, col_addr}, 32'h100, "test rst");
        $display("mid reset test done");
        give_verdict();
    end
endmodule // testbench
